// file: fifo_far_side.sv
// far-side writer and reader driving the write and read port pins
`timescale 1ns/100ps
module fifo_far_side (
	// write device pins
	output logic o_write_clock,
	output logic o_write_enable_n,
	output logic o_write_chip_select_n,
	// read device pins
	output logic o_read_clock,
	output logic o_read_enable_n,
	output logic o_read_chip_select_n
);
	initial begin
		o_write_clock = 1'h0;
		o_write_enable_n = 1'h1;
		o_write_chip_select_n = 1'h1;
		o_read_clock = 1'h0;
		o_read_enable_n = 1'h1;
		o_read_chip_select_n = 1'h1;
	end

	// clocks stand still between transfers, so each rise is exactly one event
	task automatic write_one(input logic cs_n);
		o_write_enable_n = 1'h0;
		o_write_chip_select_n = cs_n;
		#80 o_write_clock = 1'h1;
		#80 o_write_clock = 1'h0;
		#40 o_write_enable_n = 1'h1;
		o_write_chip_select_n = 1'h1;
		// idle gap so a following call never flips enable in the same step
		#40;
	endtask : write_one

	task automatic read_one(input logic cs_n);
		o_read_enable_n = 1'h0;
		o_read_chip_select_n = cs_n;
		#80 o_read_clock = 1'h1;
		#80 o_read_clock = 1'h0;
		#40 o_read_enable_n = 1'h1;
		o_read_chip_select_n = 1'h1;
		#40;
	endtask : read_one
endmodule : fifo_far_side

// file: fifo_flag_pkg.sv
// constants shared by the status-flag block and its helpers
package fifo_flag_pkg;
	// organisation: word count for the smallest part, widths of the output port
	localparam int DEPTH_WORDS = 2048;
	localparam int WORD_W      = 18;
	localparam int BYTE_W      = 9;
	localparam int OFFSET_W    = 13;

	// bit positions inside the synchronised pin vector
	localparam int P_WCLK  = 0;
	localparam int P_RCLK  = 1;
	localparam int P_SCLK  = 2;
	localparam int P_WEN   = 3;
	localparam int P_WCS   = 4;
	localparam int P_REN   = 5;
	localparam int P_RCS   = 6;
	localparam int P_SEN   = 7;
	localparam int P_SI    = 8;
	localparam int P_MRS   = 9;
	localparam int P_PRS   = 10;
	localparam int P_PFM   = 11;
	localparam int P_FIRST_WORD_FALL_THROUGH  = 12;
	localparam int P_IW9   = 13;
	localparam int P_OW9   = 14;
	localparam int P_RT    = 15;
	localparam int P_MARK  = 16;
	localparam int PIN_W   = 17;

	// flag values while a master or partial reset is held
	localparam logic FULL_FLAG_RST  = 1'b1;
	localparam logic EMPTY_FLAG_RST = 1'b0;
	localparam logic HALF_FLAG_RST  = 1'b1;
endpackage : fifo_flag_pkg

// file: fifo_status_flags.sv
// almost-full, almost-empty, half-full flags and echo read outputs
// Contract
// - standard mode: almost-full low once writes reach depth minus full offset
// - fall-through mode: almost-full low one write later, depth plus one minus m
// - depth is word count, doubled when both ports are byte wide
// - async timing: almost-full set low by write edge, high by read edge
// - sync timing: almost-full changes only on write clock edges
// - retransmit mode: almost-full compares write pointer with marked location
// - standard mode: almost-empty low while n words or fewer held
// - fall-through mode: almost-empty low while n plus one or fewer held
// - async timing: almost-empty set low by read edge, high by write edge
// - sync timing: almost-empty changes only on read clock edges
// - half-full goes low on write edge filling beyond half depth
// - half-full returns high on read edge bringing level to half or below
// - standard mode: half-full low after half depth plus one writes
// - fall-through mode: half-full low after half depth plus two writes
// - echo read clock is a delayed free-running copy of read clock
// - echo read enable low one read cycle per accepted non-empty read
// - serial bit captured on serial clock rise while serial enable low
// - output port is eighteen bits word wide, nine bits byte wide
`timescale 1ns/100ps
module fifo_status_flags
	import fifo_flag_pkg::*;
#(
	parameter int WORDS = DEPTH_WORDS
) (
	// clock and reset
	input  wire logic                i_sys_clk,
	input  wire logic                i_resetn,
	// write port pins
	input  wire logic                i_write_clock,
	input  wire logic                i_write_enable_n,
	input  wire logic                i_write_chip_select_n,
	// read port pins
	input  wire logic                i_read_clock,
	input  wire logic                i_read_enable_n,
	input  wire logic                i_read_chip_select_n,
	input  wire logic                i_mark_n,
	input  wire logic                i_retransmit_mode,
	// reset and configuration pins
	input  wire logic                i_master_reset_n,
	input  wire logic                i_partial_reset_n,
	input  wire logic                i_flag_timing_select,
	input  wire logic                i_first_word_fall_through,
	input  wire logic                i_input_byte_wide,
	input  wire logic                i_output_byte_wide,
	// serial offset pins
	input  wire logic                i_serial_clock,
	input  wire logic                i_serial_load_enable_n,
	input  wire logic                i_serial_in,
	// offsets and word from the memory, same clock
	input  wire logic [OFFSET_W-1:0] i_full_offset,
	input  wire logic [OFFSET_W-1:0] i_empty_offset,
	input  wire logic [WORD_W-1:0]   i_mem_data,
	// flags
	output logic                     o_almost_full_flag_n,
	output logic                     o_almost_empty_flag_n,
	output logic                     o_half_full_flag_n,
	// echo and data
	output logic                     o_echo_read_clock,
	output logic                     o_echo_read_enable_n,
	output logic [WORD_W-1:0]        o_data_out,
	// serial capture
	output logic [OFFSET_W-1:0]      o_serial_word,
	output logic                     o_serial_strobe
);
	localparam int CW = $clog2(2 * WORDS + 2) + 1;

	// level between two pointers, wrap-safe
	function automatic logic [CW-1:0] fill(input logic [CW-1:0] a, input logic [CW-1:0] b);
		fill = a - b;
	endfunction : fill

	pin_if #(.W(PIN_W)) pins ();

	logic [PIN_W-1:0] raw;
	assign raw = {i_mark_n, i_retransmit_mode, i_output_byte_wide, i_input_byte_wide,
		i_first_word_fall_through, i_flag_timing_select, i_partial_reset_n, i_master_reset_n,
		i_serial_in, i_serial_load_enable_n, i_read_chip_select_n, i_read_enable_n,
		i_write_chip_select_n, i_write_enable_n, i_serial_clock, i_read_clock, i_write_clock};

	pin_edge_sync #(.W(PIN_W)) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_pins    (raw),
		.pins      (pins)
	);

	serial_offset_shift #(.W(OFFSET_W)) u_serial (
		.i_sys_clk              (i_sys_clk),
		.i_resetn               (i_resetn),
		.i_sclk_rise            (pins.rise[P_SCLK]),
		.i_serial_load_enable_n (pins.lvl[P_SEN]),
		.i_serial_bit           (pins.lvl[P_SI]),
		.o_word                 (o_serial_word),
		.o_strobe               (o_serial_strobe)
	);

	logic          wr_rise;
	logic          rd_rise;
	logic          rst_fifo;
	logic          cfg_sync_q;
	logic          cfg_first_word_fall_through_q;
	logic          cfg_both9_q;
	logic          cfg_out9_q;
	logic [CW-1:0] wr_ptr_q;
	logic [CW-1:0] rd_ptr_q;
	logic [CW-1:0] mark_q;
	logic [CW-1:0] depth;
	logic [CW-1:0] eff_depth;
	logic [CW-1:0] hf_thr;
	logic [CW-1:0] level_q;
	logic [CW-1:0] level_d;
	logic [CW-1:0] wr_ptr_d;
	logic [CW-1:0] rd_ptr_d;
	logic          wr_ev;
	logic          rd_ev;
	logic          af_hit;
	logic          ae_hit;
	logic          hf_hit;

	assign wr_rise  = pins.rise[P_WCLK];
	assign rd_rise  = pins.rise[P_RCLK];
	assign rst_fifo = !pins.lvl[P_MRS] || !pins.lvl[P_PRS];

	// timing, fall-through and width modes are latched only while master reset is held; retransmit mode is read live
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			cfg_sync_q  <= 1'b0;
			cfg_first_word_fall_through_q  <= 1'b0;
			cfg_both9_q <= 1'b0;
			cfg_out9_q  <= 1'b0;
		end else if (!pins.lvl[P_MRS]) begin
			cfg_sync_q  <= pins.lvl[P_PFM];
			cfg_first_word_fall_through_q  <= pins.lvl[P_FIRST_WORD_FALL_THROUGH];
			cfg_both9_q <= pins.lvl[P_IW9] && pins.lvl[P_OW9];
			cfg_out9_q  <= pins.lvl[P_OW9];
		end
	end

	always_comb begin
		depth     = cfg_both9_q ? CW'(2 * WORDS) : CW'(WORDS);
		eff_depth = depth + CW'(cfg_first_word_fall_through_q);
		// fall-through needs one write more to pass half
		hf_thr    = (depth >> 1) + CW'(cfg_first_word_fall_through_q);
		level_q   = fill(wr_ptr_q, rd_ptr_q);
		wr_ev     = wr_rise && !pins.lvl[P_WEN] && !pins.lvl[P_WCS] && (level_q < eff_depth);
		rd_ev     = rd_rise && !pins.lvl[P_REN] && !pins.lvl[P_RCS] && (level_q != '0);
		wr_ptr_d  = wr_ptr_q + CW'(wr_ev);
		rd_ptr_d  = rd_ptr_q + CW'(rd_ev);
		level_d   = fill(wr_ptr_d, rd_ptr_d);
		// retransmit keeps the marked words, so room is counted from the mark
		af_hit    = fill(wr_ptr_d, pins.lvl[P_RT] ? mark_q : rd_ptr_d)
			>= eff_depth - CW'(i_full_offset);
		ae_hit    = level_d <= CW'(i_empty_offset) + CW'(cfg_first_word_fall_through_q);
		hf_hit    = level_d > hf_thr;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || rst_fifo) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || rst_fifo) begin
			mark_q <= '0;
		end else if (rd_rise && !pins.lvl[P_MARK]) begin
			mark_q <= rd_ptr_q;
		end
	end

	// almost-full
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || rst_fifo) begin
			o_almost_full_flag_n <= FULL_FLAG_RST;
		end else if (cfg_sync_q) begin
			if (wr_rise) begin
				o_almost_full_flag_n <= !af_hit;
			end
		end else if (wr_rise && af_hit) begin
			o_almost_full_flag_n <= 1'b0;
		end else if (rd_rise && !af_hit) begin
			o_almost_full_flag_n <= 1'b1;
		end
	end

	// almost-empty
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || rst_fifo) begin
			o_almost_empty_flag_n <= EMPTY_FLAG_RST;
		end else if (cfg_sync_q) begin
			if (rd_rise) begin
				o_almost_empty_flag_n <= !ae_hit;
			end
		end else if (rd_rise && ae_hit) begin
			o_almost_empty_flag_n <= 1'b0;
		end else if (wr_rise && !ae_hit) begin
			o_almost_empty_flag_n <= 1'b1;
		end
	end

	// half-full, moved by both clocks
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || rst_fifo) begin
			o_half_full_flag_n <= HALF_FLAG_RST;
		end else if (wr_rise && hf_hit) begin
			o_half_full_flag_n <= 1'b0;
		end else if (rd_rise && !hf_hit) begin
			o_half_full_flag_n <= 1'b1;
		end
	end

	// echo outputs; echo clock lags read clock by the sampling delay
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_echo_read_clock    <= 1'b0;
			o_echo_read_enable_n <= 1'b1;
		end else begin
			o_echo_read_clock <= pins.lvl[P_RCLK];
			if (rd_rise) begin
				o_echo_read_enable_n <= !rd_ev;
			end
		end
	end

	// byte-wide output leaves the upper lanes at zero
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_data_out <= '0;
		end else if (rd_ev) begin
			o_data_out <= cfg_out9_q ? {{(WORD_W-BYTE_W){1'b0}}, i_mem_data[BYTE_W-1:0]} : i_mem_data;
		end
	end

	AST_PAF_STD_LEVEL: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		wr_rise && cfg_sync_q && !cfg_first_word_fall_through_q && !pins.lvl[P_RT] && !rd_rise
		|=> o_almost_full_flag_n == (fill(wr_ptr_q, rd_ptr_q) < depth - CW'($past(i_full_offset))))
		else $error("almost-full wrong in standard mode");
	AST_PAF_FIRST_WORD_FALL_THROUGH_LEVEL: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		wr_rise && cfg_sync_q && cfg_first_word_fall_through_q && !pins.lvl[P_RT] && !rd_rise
		|=> o_almost_full_flag_n == (fill(wr_ptr_q, rd_ptr_q) < depth + 1'b1 - CW'($past(i_full_offset))))
		else $error("almost-full wrong in fall-through mode");
	AST_PAF_ASYNC_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		!cfg_sync_q && !$past(rst_fifo) && $rose(o_almost_full_flag_n) |-> $past(rd_rise))
		else $error("almost-full released without read edge");
	AST_PAF_SYNC_EDGE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		cfg_sync_q && !$past(rst_fifo) && $changed(o_almost_full_flag_n) |-> $past(wr_rise))
		else $error("almost-full moved off write edge");
	AST_PAE_LEVEL: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		rd_rise && cfg_sync_q && !wr_rise
		|=> o_almost_empty_flag_n == (level_q > CW'($past(i_empty_offset)) + CW'(cfg_first_word_fall_through_q)))
		else $error("almost-empty wrong for level");
	AST_PAE_ASYNC_FALL: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		!cfg_sync_q && !$past(rst_fifo) && $fell(o_almost_empty_flag_n) |-> $past(rd_rise))
		else $error("almost-empty asserted without read edge");
	AST_PAE_SYNC_EDGE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		cfg_sync_q && !$past(rst_fifo) && $changed(o_almost_empty_flag_n) |-> $past(rd_rise))
		else $error("almost-empty moved off read edge");
	AST_HF_FALL: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		!$past(rst_fifo) && $fell(o_half_full_flag_n) |-> $past(wr_rise) && (level_q > hf_thr))
		else $error("half-full set without filling past half");
	AST_HF_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		!$past(rst_fifo) && $rose(o_half_full_flag_n) |-> $past(rd_rise) && (level_q <= hf_thr))
		else $error("half-full released wrongly");
	AST_ECHO_CLOCK: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		rd_rise |=> o_echo_read_clock ##1 (o_echo_read_clock == $past(pins.lvl[P_RCLK])))
		else $error("echo clock does not follow read clock");
	AST_ECHO_ENABLE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		rd_ev |=> !o_echo_read_enable_n && (o_data_out[BYTE_W-1:0] == $past(i_mem_data[BYTE_W-1:0])))
		else $error("echo enable missing on read");
	AST_BYTE_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		cfg_out9_q && rd_ev |=> o_data_out[WORD_W-1:BYTE_W] == '0)
		else $error("upper lanes driven in byte-wide output");

	// async flags: the opposite clock edges of the ones checked above
	AST_PAF_ASYNC_FALL: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		!cfg_sync_q && !$past(rst_fifo) && $fell(o_almost_full_flag_n) |-> $past(wr_rise))
		else $error("almost-full asserted without write edge");
	AST_PAE_ASYNC_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		!cfg_sync_q && !$past(rst_fifo) && $rose(o_almost_empty_flag_n) |-> $past(wr_rise))
		else $error("almost-empty released without write edge");
	// retransmit room is counted from the mark, not the read pointer
	AST_PAF_RETRANSMIT: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		wr_rise && cfg_sync_q && pins.lvl[P_RT] && !rd_rise
		|=> o_almost_full_flag_n == (fill(wr_ptr_q, mark_q) < eff_depth - CW'($past(i_full_offset))))
		else $error("almost-full not measured against mark");
	AST_FULL_REFUSED: assert property (@(posedge i_sys_clk) disable iff (!i_resetn || rst_fifo)
		(level_q == eff_depth) && !rd_ev |=> level_q == $past(level_q))
		else $error("write accepted while full");
	AST_ECHO_CLOCK_LOW: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		$fell(pins.lvl[P_RCLK]) |=> !o_echo_read_clock)
		else $error("echo clock does not fall with read clock");
	AST_ECHO_ENABLE_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!rd_rise |=> $stable(o_echo_read_enable_n))
		else $error("echo enable moved off read edge");
	// data must stand until the next accepted read
	AST_DATA_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!rd_ev |=> $stable(o_data_out))
		else $error("data output moved without read");
endmodule : fifo_status_flags

// file: pin_edge_sync.sv
// two-stage synchroniser with rising-edge detect for a pin vector
`timescale 1ns/100ps
module pin_edge_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_resetn,
	// raw pins
	input  wire logic [W-1:0] i_pins,
	// synchronised view
	pin_if.src                pins
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// first stage feeds only the second stage
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= i_pins;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign pins.lvl  = sync_q;
	assign pins.rise = sync_q & ~prev_q;
endmodule : pin_edge_sync

// file: pin_if.sv
// synchronised pin levels and their rising-edge pulses
`timescale 1ns/100ps
interface pin_if #(
	parameter int W = 1
);
	logic [W-1:0] lvl;
	logic [W-1:0] rise;

	modport src (output lvl, output rise);
	modport dst (input lvl, input rise);
endinterface : pin_if

// file: serial_offset_shift.sv
// serial offset bit capture on the sampled serial clock
`timescale 1ns/100ps
module serial_offset_shift #(
	parameter int W = 13
) (
	// clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_resetn,
	// sampled serial pins
	input  wire logic         i_sclk_rise,
	input  wire logic         i_serial_load_enable_n,
	input  wire logic         i_serial_bit,
	// captured bits
	output logic      [W-1:0] o_word,
	output logic              o_strobe
);
	logic take;

	assign take = i_sclk_rise && !i_serial_load_enable_n;

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_word   <= '0;
			o_strobe <= 1'b0;
		end else begin
			o_strobe <= take;
			if (take) begin
				o_word <= {o_word[W-2:0], i_serial_bit};
			end
		end
	end

	AST_SERIAL_CAPTURE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		take |=> o_strobe && (o_word[0] == $past(i_serial_bit)))
		else $error("serial bit not captured");
	AST_SERIAL_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!take |=> !o_strobe && $stable(o_word))
		else $error("serial word moved without enable");
endmodule : serial_offset_shift

// file: testbench.sv
// self-checking bench for the status-flag block
`timescale 1ns/100ps
module testbench
	import fifo_flag_pkg::*;
;
	localparam int WORDS = 8;
	localparam int LIMIT = 20000;
	logic              i_sys_clk = 1'h0;
	logic              i_resetn = 1'h0;
	logic              wclk, wen_n, wcs_n, rclk, ren_n, rcs_n;
	logic              mark_n = 1'h1;
	logic              mrs_n = 1'h1;
	logic              prs_n = 1'h1;
	logic              sclk = 1'h0;
	logic              sen_n = 1'h1;
	logic              si = 1'h0;
	logic [4:0]        mode = 5'h00;
	logic [12:0]       m = 13'h0;
	logic [12:0]       n = 13'h0;
	logic [17:0]       mem = 18'h0;
	logic [17:0]       dout, e_dat;
	logic [12:0]       sword;
	logic              af, ae, hf, eclk, een, sstb, e_af, e_ae, e_hf;
	logic [4:0]        cfg [5] = '{5'h00, 5'h10, 5'h08, 5'h1e, 5'h03};
	int                error_cnt, checks_done, level, wr_tot, dep, f;
	int                cycles = 0;
	int                sstb_cnt = 0;

	always #10 i_sys_clk = ~i_sys_clk;

	// strobe pulses stand one cycle, so count them as they pass
	always @(posedge i_sys_clk) begin
		if (sstb === 1'h1) begin
			sstb_cnt <= sstb_cnt + 1;
		end
	end

	fifo_far_side fifo_far_side_i (
		.o_write_clock(wclk), .o_write_enable_n(wen_n), .o_write_chip_select_n(wcs_n),
		.o_read_clock(rclk), .o_read_enable_n(ren_n), .o_read_chip_select_n(rcs_n)
	);

	// mode bits: timing select, fall-through, input byte, output byte, retransmit
	fifo_status_flags #(.WORDS(WORDS)) fifo_status_flags_i (
		.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.i_write_clock(wclk), .i_write_enable_n(wen_n), .i_write_chip_select_n(wcs_n),
		.i_read_clock(rclk), .i_read_enable_n(ren_n), .i_read_chip_select_n(rcs_n),
		.i_mark_n(mark_n), .i_retransmit_mode(mode[0]),
		.i_master_reset_n(mrs_n), .i_partial_reset_n(prs_n),
		.i_flag_timing_select(mode[4]), .i_first_word_fall_through(mode[3]),
		.i_input_byte_wide(mode[2]), .i_output_byte_wide(mode[1]),
		.i_serial_clock(sclk), .i_serial_load_enable_n(sen_n), .i_serial_in(si),
		.i_full_offset(m), .i_empty_offset(n), .i_mem_data(mem),
		.o_almost_full_flag_n(af), .o_almost_empty_flag_n(ae), .o_half_full_flag_n(hf),
		.o_echo_read_clock(eclk), .o_echo_read_enable_n(een), .o_data_out(dout),
		.o_serial_word(sword), .o_serial_strobe(sstb)
	);

	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// retransmit measures against the mark, taken at read pointer zero
	function automatic logic calc_af();
		return !((mode[0] ? wr_tot : level) >= dep + f - int'(m));
	endfunction : calc_af

	function automatic logic calc_ae();
		return !(level <= int'(n) + f);
	endfunction : calc_ae

	function automatic logic calc_hf();
		return !(level > dep / 2 + f);
	endfunction : calc_hf

	task automatic chk_flags();
		check("almost_full", 18'(af), 18'(e_af));
		check("almost_empty", 18'(ae), 18'(e_ae));
		check("half_full", 18'(hf), 18'(e_hf));
	endtask : chk_flags

	task automatic pulse_reset(input logic master);
		@(posedge i_sys_clk);
		mrs_n <= !master;
		prs_n <= master;
		repeat (8) @(posedge i_sys_clk);
		mrs_n <= 1'h1;
		prs_n <= 1'h1;
		repeat (8) @(posedge i_sys_clk);
		#1;
		level = 0;
		wr_tot = 0;
		e_af = FULL_FLAG_RST;
		e_ae = EMPTY_FLAG_RST;
		e_hf = HALF_FLAG_RST;
		chk_flags();
	endtask : pulse_reset

	task automatic do_write(input logic cs_n);
		fifo_far_side_i.write_one(cs_n);
		if (!cs_n && level < dep + f) begin
			level++;
			wr_tot++;
		end
		e_af = calc_af();
		e_hf = calc_hf();
		if (!mode[4]) e_ae = calc_ae();
		chk_flags();
	endtask : do_write

	task automatic do_read(input logic cs_n, input logic mk_n);
		logic ok;
		ok = !cs_n && level > 0;
		@(posedge i_sys_clk);
		mem <= 18'($urandom);
		mark_n <= mk_n;
		#1;
		fork
			fifo_far_side_i.read_one(cs_n);
			begin
				#180 check("echo_clock_high", 18'(eclk), 18'h1);
				#120 check("echo_clock_low", 18'(eclk), 18'h0);
			end
		join
		if (ok) level--;
		e_dat = mode[1] ? {9'h0, mem[8:0]} : mem;
		e_ae = calc_ae();
		e_hf = calc_hf();
		if (!mode[4]) e_af = calc_af();
		check("echo_enable", 18'(een), 18'(!ok));
		if (ok) check("data_out", dout, e_dat);
		chk_flags();
	endtask : do_read

	task automatic serial_load(input logic en_n, input logic [12:0] w);
		for (int i = 12; i >= 0; i--) begin
			@(posedge i_sys_clk);
			sen_n <= en_n;
			si <= w[i];
			repeat (4) @(posedge i_sys_clk);
			sclk <= 1'h1;
			repeat (4) @(posedge i_sys_clk);
			sclk <= 1'h0;
		end
		repeat (6) @(posedge i_sys_clk);
		sen_n <= 1'h1;
		#1;
	endtask : serial_load

	initial begin
		logic [12:0] w;
		error_cnt = 0;
		checks_done = 0;
		void'($urandom(8));
		repeat (4) @(posedge i_sys_clk);
		i_resetn <= 1'h1;
		w = 13'($urandom);
		serial_load(1'h0, w);
		check("serial_word", 18'(sword), 18'(w));
		check("serial_strobes", 18'(sstb_cnt), 18'h0d);
		serial_load(1'h1, ~w);
		check("serial_word_held", 18'(sword), 18'(w));
		check("serial_strobes_held", 18'(sstb_cnt), 18'h0d);
		for (int k = 0; k < 5; k++) begin
			@(posedge i_sys_clk);
			mode <= cfg[k];
			m <= 13'(1 + $urandom_range(2));
			n <= 13'($urandom_range(2));
			dep = (cfg[k][2] && cfg[k][1]) ? 2 * WORDS : WORDS;
			f = int'(cfg[k][3]);
			pulse_reset(1'h1);
			do_read(1'h1, 1'h0);
			do_write(1'h1);
			repeat (dep + f + 1) do_write(1'h0);
			pulse_reset(1'h0);
			repeat (dep + f + 1) do_write(1'h0);
			repeat (dep + f + 2) do_read(1'h0, 1'h1);
			$display("test %0d done", k);
		end
		test_done();
	end
endmodule : testbench
